// ==== verilog/swk_pkg.sv ====
// Constants for the selective-wake recovery and oscillator configuration.
// Assumes an 8-bit register file reached over a 16-bit serial frame.
// Overview of operation
// - Option bit 7 picks the standard (0) or low-power (1) wake receiver.
// - Receiver-select bit is accessible only while trim enable equals 11.
// - Options bits 4:0 hold coarse trim 0..31, writable only when unlocked.
// - Reserved bits of options and both recovery controls always read zero.
// - Calibration high byte is read-only; writes to it do nothing.
// - Calibration low byte is read-only and completes the calibration result.
// - Filter select 00/01/10/11 gives constant 8, 16, 32 or adaptive.
// - Adaptive: edge spacing 2-3 bits gives 32, 4-8 gives 16, 9-10 gives 8.
// - Clock source field picks 80, 40, 20 or 10 MHz for the recovery unit.
// - Power-on or soft reset clears receiver bit; soft reset keeps trim, power-on reloads factory trim.
// - Restart keeps receiver bit, trim and clock select unchanged.
// - Measured bit time above the upper limit is clamped to that limit.
`default_nettype none
package swk_pkg;
	localparam logic [6:0] SWK_ADDR_OPTIONS = 7'h39;
	localparam logic [6:0] SWK_ADDR_CAL_HIGH = 7'h3A;
	localparam logic [6:0] SWK_ADDR_CAL_LOW = 7'h3B;
	localparam logic [6:0] SWK_ADDR_CTRL_ONE = 7'h3C;
	localparam logic [6:0] SWK_ADDR_CTRL_TWO = 7'h3D;
	localparam int SWK_OPT_RXSEL_BIT = 7;
	localparam int SWK_OPT_TRIM_MSB = 4;
	localparam int SWK_CTRL1_FILT_LSB = 2;
	localparam int SWK_CTRL1_EN_BIT = 0;
	localparam logic [1:0] SWK_TRIM_UNLOCK = 2'h3;
	localparam logic [1:0] SWK_FILT_RST = 2'h1;
	localparam logic [1:0] SWK_CLKSEL_RST = 2'h0;
	localparam logic [1:0] SWK_FILT_8 = 2'h0;
	localparam logic [1:0] SWK_FILT_16 = 2'h1;
	localparam logic [1:0] SWK_FILT_32 = 2'h2;
	localparam logic [1:0] SWK_FILT_ADAPT = 2'h3;
	localparam logic [5:0] SWK_TC_8 = 6'h08;
	localparam logic [5:0] SWK_TC_16 = 6'h10;
	localparam logic [5:0] SWK_TC_32 = 6'h20;
	localparam logic [4:0] SWK_SPACE_2 = 5'h02;
	localparam logic [4:0] SWK_SPACE_3 = 5'h03;
	localparam logic [4:0] SWK_SPACE_4 = 5'h04;
	localparam logic [4:0] SWK_SPACE_8 = 5'h08;
	localparam logic [4:0] SWK_SPACE_9 = 5'h09;
	localparam logic [4:0] SWK_SPACE_10 = 5'h0A;
	localparam logic [4:0] SWK_FRAME_BITS = 5'h10;
	localparam logic [4:0] SWK_ADDR_BITS = 5'h08;
endpackage
`default_nettype wire

// ==== verilog/swk_config.sv ====
// Selective-wake recovery and oscillator configuration registers with the
// serial register port, recovery clock divider and adaptive filter choice.
// Assumes all pins are synchronous to ref_clk and sclk is well below it.
`default_nettype none
module swk_config
	import swk_pkg::*;
(
	input wire logic ref_clk,
	input wire logic reset,
	input wire logic soft_reset,
	input wire logic restart,
	input wire logic [1:0] trim_enable,
	input wire logic [4:0] factory_coarse_trim,
	input wire logic [7:0] osc_calibration_high_byte,
	input wire logic [7:0] osc_calibration_low_byte,
	input wire logic [7:0] bit_time_length,
	input wire logic [7:0] bit_time_upper_limit,
	input wire logic [7:0] bit_time_lower_limit,
	input wire logic can_rxd,
	input wire logic spi_cs_n,
	input wire logic spi_sclk,
	input wire logic spi_mosi,
	output logic spi_miso,
	output logic spi_miso_oe,
	output logic wake_receiver_select,
	output logic [4:0] oscillator_trim,
	output logic recovery_enable,
	output logic [1:0] filter_time_constant_select,
	output logic [1:0] recovery_clock_select,
	output logic recovery_tick,
	output logic [5:0] filter_time_constant,
	output logic [7:0] clamped_bit_time
);
	typedef struct packed {
		logic sclk_q;
		logic [4:0] bit_cnt;
		logic [7:0] shreg;
		logic [6:0] addr;
		logic wr;
		logic [7:0] rdb;
		logic miso;
		logic miso_oe;
		logic rx_sel;
		logic [4:0] trim;
		logic en;
		logic [1:0] filt;
		logic [1:0] clksel;
		logic [2:0] div;
		logic tick;
		logic rxd_q;
		logic [7:0] tq;
		logic [3:0] bits;
		logic [5:0] adapt_tc;
		logic [5:0] tc;
		logic [7:0] bt;
	} swk_state_t;

	swk_state_t st_ff;
	swk_state_t nxt_st;

	logic unlocked;
	assign unlocked = (trim_enable == SWK_TRIM_UNLOCK);

	// Read view of one register; reserved bits come back as zero
	function automatic logic [7:0] rd_reg(input logic [6:0] a,
		input swk_state_t s, input logic unl);
		logic [7:0] v;
		v = 8'h00;
		case (a)
			SWK_ADDR_OPTIONS: begin
				v[SWK_OPT_RXSEL_BIT] = s.rx_sel & unl;
				v[SWK_OPT_TRIM_MSB:0] = s.trim;
			end
			SWK_ADDR_CAL_HIGH: v = osc_calibration_high_byte;
			SWK_ADDR_CAL_LOW: v = osc_calibration_low_byte;
			SWK_ADDR_CTRL_ONE: begin
				v[SWK_CTRL1_FILT_LSB +: 2] = s.filt;
				v[SWK_CTRL1_EN_BIT] = s.en;
			end
			SWK_ADDR_CTRL_TWO: v[1:0] = s.clksel;
			default: v = 8'h00;
		endcase
		return v;
	endfunction

	// Constant chosen from a measured edge spacing in whole bits
	function automatic logic [5:0] pick_tc(input logic [4:0] sp,
		input logic [5:0] keep);
		logic [5:0] r;
		r = keep;
		if (sp >= SWK_SPACE_2 && sp <= SWK_SPACE_3) begin
			r = SWK_TC_32;
		end else if (sp >= SWK_SPACE_4 && sp <= SWK_SPACE_8) begin
			r = SWK_TC_16;
		end else if (sp >= SWK_SPACE_9 && sp <= SWK_SPACE_10) begin
			r = SWK_TC_8;
		end
		return r;
	endfunction

	logic sclk_rise;
	logic sclk_fall;
	logic [7:0] wdata;
	logic [2:0] div_lim;
	logic [7:0] half_bt;
	logic [4:0] spacing;
	logic rxd_fall;

	always_comb begin
		nxt_st = st_ff;
		sclk_rise = spi_sclk & ~st_ff.sclk_q;
		sclk_fall = ~spi_sclk & st_ff.sclk_q;
		wdata = st_ff.shreg;
		div_lim = 3'((4'h1 << st_ff.clksel) - 4'h1);
		half_bt = {1'b0, st_ff.bt[7:1]};
		spacing = {1'b0, st_ff.bits} + {4'h0, (st_ff.tq >= half_bt)};
		rxd_fall = st_ff.rxd_q & ~can_rxd;

		nxt_st.sclk_q = spi_sclk;
		nxt_st.rxd_q = can_rxd;

		// Serial frame: 7 address bits, write flag, 8 data bits, LSB first
		nxt_st.miso_oe = ~spi_cs_n;
		if (spi_cs_n) begin
			// Commit only a complete frame so a torn one changes nothing
			if (st_ff.bit_cnt == SWK_FRAME_BITS && st_ff.wr) begin
				case (st_ff.addr)
					SWK_ADDR_OPTIONS: begin
						if (unlocked) begin
							nxt_st.rx_sel = wdata[SWK_OPT_RXSEL_BIT];
							nxt_st.trim = wdata[SWK_OPT_TRIM_MSB:0];
						end
						// Locked: gated bits hold, nothing else moves
					end
					SWK_ADDR_CTRL_ONE: begin
						nxt_st.filt = wdata[SWK_CTRL1_FILT_LSB +: 2];
						nxt_st.en = wdata[SWK_CTRL1_EN_BIT];
					end
					SWK_ADDR_CTRL_TWO: nxt_st.clksel = wdata[1:0];
					default: begin
					end
				endcase
			end
			nxt_st.bit_cnt = 5'h00;
			nxt_st.miso = 1'b0;
		end else begin
			if (sclk_rise && st_ff.bit_cnt < SWK_FRAME_BITS) begin
				nxt_st.shreg = {spi_mosi, st_ff.shreg[7:1]};
				nxt_st.bit_cnt = st_ff.bit_cnt + 5'h01;
				if (st_ff.bit_cnt == SWK_ADDR_BITS - 5'h01) begin
					nxt_st.addr = st_ff.shreg[7:1];
					nxt_st.wr = spi_mosi;
					nxt_st.rdb = rd_reg(st_ff.shreg[7:1], st_ff, unlocked);
				end
			end
			if (sclk_fall && st_ff.bit_cnt >= SWK_ADDR_BITS
				&& st_ff.bit_cnt < SWK_FRAME_BITS) begin
				nxt_st.miso = st_ff.rdb[st_ff.bit_cnt[2:0]];
			end
		end

		// Recovery clock as an enable: divide by 1, 2, 4 or 8
		nxt_st.tick = (st_ff.div >= div_lim);
		nxt_st.div = (st_ff.div >= div_lim) ? 3'h0 : st_ff.div + 3'h1;

		// Limits keep a wild bit time from skewing the spacing count
		if (bit_time_length > bit_time_upper_limit) begin
			nxt_st.bt = bit_time_upper_limit;
		end else if (bit_time_length < bit_time_lower_limit) begin
			nxt_st.bt = bit_time_lower_limit;
		end else begin
			nxt_st.bt = bit_time_length;
		end

		// Falling-edge spacing measured in recovery ticks, then whole bits
		if (!st_ff.en) begin
			nxt_st.tq = 8'h00;
			nxt_st.bits = 4'h0;
		end else if (rxd_fall) begin
			nxt_st.adapt_tc = pick_tc(spacing, st_ff.adapt_tc);
			nxt_st.tq = 8'h00;
			nxt_st.bits = 4'h0;
		end else if (st_ff.tick) begin
			if (st_ff.tq + 8'h01 >= st_ff.bt) begin
				nxt_st.tq = 8'h00;
				if (st_ff.bits != 4'hF) begin
					nxt_st.bits = st_ff.bits + 4'h1;
				end
			end else begin
				nxt_st.tq = st_ff.tq + 8'h01;
			end
		end

		case (st_ff.filt)
			SWK_FILT_8: nxt_st.tc = SWK_TC_8;
			SWK_FILT_16: nxt_st.tc = SWK_TC_16;
			SWK_FILT_32: nxt_st.tc = SWK_TC_32;
			SWK_FILT_ADAPT: nxt_st.tc = st_ff.adapt_tc;
			default: nxt_st.tc = SWK_TC_16;
		endcase

		// Restart keeps receiver, trim and clock select untouched
		if (restart) begin
			nxt_st.clksel = st_ff.clksel;
			nxt_st.rx_sel = st_ff.rx_sel;
			nxt_st.trim = st_ff.trim;
		end
		if (soft_reset) begin
			nxt_st.rx_sel = 1'b0;
			nxt_st.trim = st_ff.trim;
			nxt_st.filt = SWK_FILT_RST;
			nxt_st.en = 1'b0;
			nxt_st.clksel = SWK_CLKSEL_RST;
		end
		if (reset) begin
			nxt_st = '0;
			// Trim is factory data, so power-on reloads it rather than zeroing
			nxt_st.trim = factory_coarse_trim;
			nxt_st.filt = SWK_FILT_RST;
			nxt_st.clksel = SWK_CLKSEL_RST;
			nxt_st.adapt_tc = SWK_TC_16;
			nxt_st.tc = SWK_TC_16;
			nxt_st.sclk_q = 1'b0;
			nxt_st.rxd_q = 1'b1;
		end
	end

	always_ff @(posedge ref_clk) begin
		st_ff <= nxt_st;
	end

	assign spi_miso = st_ff.miso;
	assign spi_miso_oe = st_ff.miso_oe;
	assign wake_receiver_select = st_ff.rx_sel;
	assign oscillator_trim = st_ff.trim;
	assign recovery_enable = st_ff.en;
	assign filter_time_constant_select = st_ff.filt;
	assign recovery_clock_select = st_ff.clksel;
	assign recovery_tick = st_ff.tick;
	assign filter_time_constant = st_ff.tc;
	assign clamped_bit_time = st_ff.bt;
endmodule
`default_nettype wire

// ==== verification/swk_config_properties.sv ====
// Port checker for the wake configuration block.
// Bound into swk_config; one clock, synchronous reset.
`default_nettype none
module swk_config_properties
	import swk_pkg::*;
(
	input wire logic ref_clk,
	input wire logic reset,
	input wire logic soft_reset,
	input wire logic restart,
	input wire logic [1:0] trim_enable,
	input wire logic [7:0] bit_time_length,
	input wire logic [7:0] bit_time_upper_limit,
	input wire logic spi_cs_n,
	input wire logic spi_miso_oe,
	input wire logic wake_receiver_select,
	input wire logic [4:0] oscillator_trim,
	input wire logic recovery_enable,
	input wire logic [1:0] filter_time_constant_select,
	input wire logic [1:0] recovery_clock_select,
	input wire logic recovery_tick,
	input wire logic [5:0] filter_time_constant,
	input wire logic [7:0] clamped_bit_time
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (reset);
	trim_lock_a: assert property (
		(trim_enable != SWK_TRIM_UNLOCK)[*3] |-> $stable(oscillator_trim))
		else $error("trim moved while locked");
	rxsel_lock_a: assert property (
		(trim_enable != SWK_TRIM_UNLOCK && !soft_reset)[*3]
		|-> $stable(wake_receiver_select)) else $error("rx select moved");
	filt_fixed_a: assert property (
		// The constant lags its select by one edge, so wait for a steady select
		$stable(filter_time_constant_select)
		&& filter_time_constant_select != SWK_FILT_ADAPT |->
		filter_time_constant == (SWK_TC_8 << filter_time_constant_select))
		else $error("wrong filter constant");
	tick_full_a: assert property (
		(recovery_clock_select == 2'h0)[*3] |-> recovery_tick)
		else $error("tick missing at full rate");
	clamp_high_a: assert property (
		!$past(reset) && $past(bit_time_length) > $past(bit_time_upper_limit)
		|-> clamped_bit_time == $past(bit_time_upper_limit))
		else $error("bit time not clamped");
	restart_keep_a: assert property (
		(restart && !soft_reset)[*3] |-> $stable(recovery_clock_select)
		&& $stable(wake_receiver_select) && $stable(oscillator_trim))
		else $error("restart changed a field");
	soft_clear_a: assert property (
		soft_reset |-> ##[1:2] !wake_receiver_select && !recovery_enable
		&& recovery_clock_select == SWK_CLKSEL_RST
		&& filter_time_constant_select == SWK_FILT_RST)
		else $error("soft reset values wrong");
	miso_idle_a: assert property (spi_cs_n[*2] |-> !spi_miso_oe)
		else $error("miso driven while deselected");
	cover property (recovery_enable
		&& filter_time_constant_select == SWK_FILT_ADAPT);
	cover property (restart && recovery_clock_select == 2'h3);
	cover property ($rose(wake_receiver_select));
endmodule
bind swk_config swk_config_properties chk_u (.*);
`default_nettype wire

// ==== verification/swk_can_node.sv ====
// CAN node model: recessive idle, falling edges at chosen bit spacing.
// Called by the bench; output changes just after ref_clk edges.
`default_nettype none
module swk_can_node (
	input wire logic ref_clk,
	output logic can_rxd
);
	timeunit 1ns;
	timeprecision 1ps;
	initial can_rxd = 1'b1;
	// Long idle after each pair so the next edge falls outside range
	task automatic send(input int gap, input int bt);
		repeat (2) begin
			@(posedge ref_clk) can_rxd <= 1'b0;
			repeat (bt) @(posedge ref_clk);
			can_rxd <= 1'b1;
			repeat ((gap - 1) * bt) @(posedge ref_clk);
		end
		repeat (12 * bt) @(posedge ref_clk);
	endtask
endmodule
`default_nettype wire

// ==== verification/testbench.sv ====
// Self-checking bench: serial register accesses with expected values.
// Drives a CAN node model on can_rxd; one 125 MHz clock.
`default_nettype none
module testbench
	import swk_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic ref_clk = 1'b0, reset = 1'b1, soft_reset = 1'b0, restart = 1'b0;
	logic [1:0] trim_enable = 2'h3;
	logic [4:0] factory_coarse_trim = 5'h15;
	logic [7:0] osc_calibration_high_byte = 8'h5A;
	logic [7:0] osc_calibration_low_byte = 8'hC3;
	logic [7:0] bit_time_length = 8'hA0;
	logic [7:0] bit_time_upper_limit = 8'hA8;
	logic [7:0] bit_time_lower_limit = 8'h98;
	logic can_rxd, spi_cs_n = 1'b1, spi_sclk = 1'b0, spi_mosi = 1'b0;
	logic spi_miso, spi_miso_oe, wake_receiver_select, recovery_enable;
	logic recovery_tick;
	logic [4:0] oscillator_trim;
	logic [1:0] filter_time_constant_select, recovery_clock_select;
	logic [5:0] filter_time_constant;
	logic [7:0] clamped_bit_time, q;
	int n_mismatch = 0, total_checks = 0, n;
	int gap[3] = '{2, 5, 10};
	always #4 ref_clk = ~ref_clk;
	swk_config dut_u (.*);
	swk_can_node can_u (.ref_clk(ref_clk), .can_rxd(can_rxd));
	task automatic chk(input string nm, input logic [7:0] s, e);
		total_checks++;
		if (s !== e) begin
			n_mismatch++;
			$display("CHECK FAILED %s expected %h seen %h", nm, e, s);
		end
	endtask
	task automatic xfer(input logic [6:0] a, input logic w, input logic [7:0] d);
		logic [15:0] f;
		f = {d, w, a};
		spi_cs_n <= 1'b0;
		for (int i = 0; i < 16; i++) begin
			@(posedge ref_clk) spi_mosi <= f[i];
			@(posedge ref_clk) spi_sclk <= 1'b1;
			repeat (2) @(posedge ref_clk);
			spi_sclk <= 1'b0;
			if (i > 7) q[i-8] = spi_miso;
		end
		@(posedge ref_clk) spi_cs_n <= 1'b1;
		repeat (3) @(posedge ref_clk);
	endtask
	task automatic rd(input string nm, input logic [6:0] a, input logic [7:0] e);
		xfer(a, 1'b0, 8'h00);
		chk(nm, q, e);
	endtask
	task automatic finish_test();
		$display("checks %0d mismatches %0d", total_checks, n_mismatch);
		if (n_mismatch == 0 && total_checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	initial begin
		repeat (60000) @(posedge ref_clk);
		n_mismatch++;
		finish_test();
	end
	initial begin
		repeat (8) @(posedge ref_clk);
		reset <= 1'b0;
		@(posedge ref_clk);
		rd("opt", SWK_ADDR_OPTIONS, 8'h15);
		rd("ctl1", SWK_ADDR_CTRL_ONE, 8'h04);
		xfer(SWK_ADDR_CAL_HIGH, 1'b1, 8'hFF);
		rd("calh", SWK_ADDR_CAL_HIGH, 8'h5A);
		rd("call", SWK_ADDR_CAL_LOW, 8'hC3);
		rd("unmapped", 7'h40, 8'h00);
		xfer(SWK_ADDR_OPTIONS, 1'b1, 8'hF5);
		rd("opt", SWK_ADDR_OPTIONS, 8'h95);
		xfer(SWK_ADDR_OPTIONS, 1'b1, 8'h8A);
		rd("opt", SWK_ADDR_OPTIONS, 8'h8A);
		trim_enable <= 2'h1;
		rd("lockrd", SWK_ADDR_OPTIONS, 8'h0A);
		xfer(SWK_ADDR_OPTIONS, 1'b1, 8'h00);
		chk("rxsel", {7'h0, wake_receiver_select}, 8'h01);
		chk("trim", {3'h0, oscillator_trim}, 8'h0A);
		trim_enable <= 2'h3;
		xfer(SWK_ADDR_CTRL_ONE, 1'b1, 8'hF3);
		rd("ctl1", SWK_ADDR_CTRL_ONE, 8'h01);
		chk("en", {7'h0, recovery_enable}, 8'h01);
		for (int s = 0; s < 3; s++) begin
			xfer(SWK_ADDR_CTRL_ONE, 1'b1, 8'(s * 4));
			chk("tc", 8'(filter_time_constant), 8'(8 << s));
		end
		for (int c = 0; c < 4; c++) begin
			xfer(SWK_ADDR_CTRL_TWO, 1'b1, 8'(c) | 8'hFC);
			rd("ctl2", SWK_ADDR_CTRL_TWO, 8'(c));
			n = 0;
			repeat (16) begin
				@(posedge ref_clk);
				n += (recovery_tick === 1'b1) ? 1 : 0;
			end
			chk("ticks", 8'(n), 8'(16 >> c));
		end
		restart <= 1'b1;
		repeat (4) @(posedge ref_clk);
		restart <= 1'b0;
		rd("ctl2", SWK_ADDR_CTRL_TWO, 8'h03);
		rd("opt", SWK_ADDR_OPTIONS, 8'h8A);
		soft_reset <= 1'b1;
		@(posedge ref_clk);
		soft_reset <= 1'b0;
		rd("opt", SWK_ADDR_OPTIONS, 8'h0A);
		rd("ctl2", SWK_ADDR_CTRL_TWO, 8'h00);
		bit_time_length <= 8'hC0;
		repeat (2) @(posedge ref_clk);
		chk("clamp", clamped_bit_time, 8'hA8);
		bit_time_length <= 8'h80;
		repeat (2) @(posedge ref_clk);
		chk("clamplo", clamped_bit_time, 8'h98);
		bit_time_length <= 8'hA0;
		xfer(SWK_ADDR_CTRL_ONE, 1'b1, 8'h0D);
		for (int g = 0; g < 3; g++) begin
			can_u.send(gap[g], 160);
			chk("adapt", 8'(filter_time_constant), 8'(32 >> g));
		end
		finish_test();
	end
endmodule
`default_nettype wire
